// ===== iri_top.sv
// Function
// - non-reading query replies under 80 chars
// - reading SD.DDDDDDDDESDD, commas, NL or CR
// - mantissa and exponent sign always sent
// - clear keeps status, errors and settings
// - clear aborts measurement in progress
// - clear returns trigger to idle
// - clear empties input and output buffers
// - after clear parse restarts at start
// - serial control-C acts as device clear
// - DTR true after any clear
// - address 31 talks without being addressed
// - serial and 31 sends readings in local
// - address 0..31, default 22
// - settings kept across interface reset
// - one interface only, parallel default
// - baud 300..9600, default 9600
// - parity fixes width, even 7 default
// - three commands select command language
// - calibration only in native language
// - legacy A ignores cal, clear skips selftest
module iri_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic nv_rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic dev_clear_i,
  input wire iri_pkg::iri_byte_t rx_i,
  input wire logic local_mode_i,
  input wire logic rdg_valid_i,
  input wire iri_pkg::iri_rdg_t rdg_i,
  input wire logic rdg_last_i,
  output logic rdg_ready_o,
  output iri_pkg::iri_byte_t tx_o,
  input wire logic tx_ready_i,
  output logic talk_only_o,
  output logic par_en_o,
  output logic ser_en_o,
  output logic meas_abort_o,
  output logic trig_idle_o,
  output logic parse_restart_o,
  output logic cal_exec_o,
  output logic selftest_o,
  output logic dtr_o,
  output iri_pkg::iri_cfg_t cfg_o
);
  import iri_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire logic acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire logic wr = acc & wb_we_i & wb_sel_i[0];
  wire logic hit_cfg = wb_adr_i == IRI_CFG_OFF;
  wire logic hit_cmd = wb_adr_i == IRI_CMD_OFF;
  wire logic hit_rdg = wb_adr_i == IRI_RDG_OFF;
  wire logic hit_txd = wb_adr_i == IRI_TXD_OFF;
  wire logic hit_qry = wb_adr_i == IRI_QRY_OFF;
  wire logic [1:0] lang_cmd = wb_dat_i[IRI_CMD_LANG_LSB +: 2];
  wire logic cmd_wr = wr & hit_cmd;
  wire logic sw_clear = cmd_wr & wb_dat_i[IRI_CMD_CLR_BIT];
  wire logic ctrl_c = rx_i.valid & ser_en_o & (rx_i.data == IRI_CTRL_C);
  wire logic clear = dev_clear_i | sw_clear | ctrl_c;

  ////////////////////////////////////////////////////////////////////////////
  // settings; only the separate storage reset restores them
  iri_cfg_t cfg_reg, cfg_next;
  wire logic [4:0] new_addr = wb_dat_i[IRI_ADDR_LSB +: 5];
  wire logic [2:0] new_baud = wb_dat_i[IRI_BAUD_LSB +: 3];
  wire logic [1:0] new_par = wb_dat_i[IRI_PAR_LSB +: 2];
  wire logic [1:0] new_lang = wb_dat_i[IRI_LANG_LSB +: 2];
  always_comb begin
    cfg_next = cfg_reg;
    if (wr & hit_cfg) begin
      cfg_next.addr = new_addr;
      cfg_next.serial_sel = wb_dat_i[IRI_IFSEL_BIT];
      if (new_baud <= 3'(IRI_B9600)) cfg_next.baud = iri_baud_t'(new_baud);
      if (new_par <= 2'(IRI_PAR_ODD)) cfg_next.par = iri_par_t'(new_par);
      if (new_lang <= 2'(IRI_LANG_LEGACY_B)) cfg_next.lang = iri_lang_t'(new_lang);
    end
    // language commands
    if (cmd_wr) begin
      case (lang_cmd)
        IRI_CMD_NATIVE: cfg_next.lang = IRI_LANG_NATIVE;
        IRI_CMD_LEG_A: cfg_next.lang = IRI_LANG_LEGACY_A;
        IRI_CMD_LEG_B: cfg_next.lang = IRI_LANG_LEGACY_B;
        default: cfg_next.lang = cfg_next.lang;
      endcase
    end
  end
  // clear never touches settings
  always_ff @(posedge clk_i or negedge nv_rst_n_i) begin
    if (!nv_rst_n_i) cfg_reg <= IRI_CFG_RST;
    else cfg_reg <= cfg_next;
  end
  assign cfg_o = cfg_reg;
  assign ser_en_o = cfg_reg.serial_sel;
  assign par_en_o = ~cfg_reg.serial_sel;
  wire logic [3:0] char_bits = (cfg_reg.par == IRI_PAR_NONE) ? 4'h8 : 4'h7;
  wire logic talk_only = cfg_reg.addr == IRI_TALK_ONLY;
  assign talk_only_o = talk_only;

  ////////////////////////////////////////////////////////////////////////////
  // clear side effects and calibration gating
  logic [2:0] pulse_reg;
  logic dtr_reg;
  logic cal_reg;
  wire logic native = cfg_reg.lang == IRI_LANG_NATIVE;
  wire logic cal_req = cmd_wr & wb_dat_i[IRI_CMD_CAL_BIT];
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pulse_reg <= 3'h0;
      dtr_reg <= 1'b1;
      cal_reg <= 1'b0;
    end else begin
      pulse_reg <= {3{clear}};
      dtr_reg <= clear | dtr_reg;
      cal_reg <= cal_req & native;
    end
  end
  assign meas_abort_o = pulse_reg[0];
  assign trig_idle_o = pulse_reg[1];
  assign parse_restart_o = pulse_reg[2];
  assign dtr_o = dtr_reg;
  assign cal_exec_o = cal_reg;
  // no mode runs self-test on clear; legacy A explicitly skips it
  assign selftest_o = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // output formatter: reading characters, or query string bytes
  typedef enum logic [2:0] {
    IRI_IDLE = 3'b001, IRI_RDG = 3'b010, IRI_QRY = 3'b100
  } iri_st_t;
  iri_st_t st_reg, st_next;
  iri_rdg_t rdg_reg;
  logic last_reg;
  logic [4:0] idx_reg;
  logic [6:0] qcnt_reg;
  iri_byte_t tx_reg;
  logic qry_seen_reg;
  // readings go out whenever not talk only; parallel talk only always, serial talk only in local
  wire logic may_talk = talk_only ? (par_en_o | local_mode_i) : 1'b1;
  wire logic tx_free = ~tx_reg.valid | tx_ready_i;
  wire logic take_rdg = (st_reg == IRI_IDLE) & rdg_valid_i & may_talk & ~clear;
  assign rdg_ready_o = take_rdg;
  wire logic qry_wr = wr & hit_qry & (st_reg != IRI_RDG) & tx_free;
  wire logic [7:0] term = par_en_o ? IRI_NL : IRI_CR;
  function automatic logic [7:0] dig(input logic [3:0] d);
    dig = 8'h30 + {4'h0, d};
  endfunction
  logic [7:0] rdg_ch;
  always_comb begin
    case (idx_reg)
      5'h00: rdg_ch = rdg_reg.neg ? 8'h2d : 8'h2b;
      5'h01: rdg_ch = dig(rdg_reg.lead);
      5'h02: rdg_ch = 8'h2e;
      5'h03: rdg_ch = dig(rdg_reg.frac[31:28]);
      5'h04: rdg_ch = dig(rdg_reg.frac[27:24]);
      5'h05: rdg_ch = dig(rdg_reg.frac[23:20]);
      5'h06: rdg_ch = dig(rdg_reg.frac[19:16]);
      5'h07: rdg_ch = dig(rdg_reg.frac[15:12]);
      5'h08: rdg_ch = dig(rdg_reg.frac[11:8]);
      5'h09: rdg_ch = dig(rdg_reg.frac[7:4]);
      5'h0a: rdg_ch = dig(rdg_reg.frac[3:0]);
      5'h0b: rdg_ch = 8'h45;
      5'h0c: rdg_ch = rdg_reg.exp_neg ? 8'h2d : 8'h2b;
      5'h0d: rdg_ch = dig(rdg_reg.exp[7:4]);
      5'h0e: rdg_ch = dig(rdg_reg.exp[3:0]);
      default: rdg_ch = last_reg ? term : IRI_COMMA;
    endcase
  end
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      IRI_IDLE: begin
        if (take_rdg) st_next = IRI_RDG;
        else if (qry_wr) st_next = IRI_QRY;
      end
      IRI_RDG: if (tx_free && idx_reg == IRI_RDG_LEN) st_next = IRI_IDLE;
      IRI_QRY: if (qry_wr && wb_dat_i[7:0] == term) st_next = IRI_IDLE;
      default: st_next = IRI_IDLE;
    endcase
    if (clear) st_next = IRI_IDLE;
  end
  // query bytes 79 to 128 are dropped and the terminator sent in their place; the count then wraps
  wire logic q_full = qcnt_reg >= IRI_QRY_MAX - 7'h1;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= IRI_IDLE;
      rdg_reg <= '0;
      last_reg <= 1'b0;
      idx_reg <= 5'h0;
      qcnt_reg <= 7'h0;
      tx_reg <= '0;
      qry_seen_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      if (take_rdg) begin
        rdg_reg <= rdg_i;
        last_reg <= rdg_last_i;
        idx_reg <= 5'h0;
      end else if (st_reg == IRI_RDG && tx_free) begin
        idx_reg <= idx_reg + 5'h1;
      end
      if (clear) begin
        tx_reg <= '0;
        qcnt_reg <= 7'h0;
      end else if (st_reg == IRI_RDG && tx_free) begin
        tx_reg <= '{valid: 1'b1, data: rdg_ch};
      end else if (qry_wr) begin
        tx_reg <= '{valid: 1'b1, data: q_full ? term : wb_dat_i[7:0]};
        qcnt_reg <= (wb_dat_i[7:0] == term) ? 7'h0 : qcnt_reg + 7'h1;
      end else if (tx_ready_i) begin
        tx_reg.valid <= 1'b0;
      end
      qry_seen_reg <= rx_i.valid & ~ctrl_c; // input byte accepted this cycle
    end
  end
  assign tx_o = tx_reg;

  ////////////////////////////////////////////////////////////////////////////
  // wishbone ack and read data
  logic ack_reg;
  logic [31:0] rd_reg;
  wire logic [31:0] stat_w = {19'h0, char_bits, 1'b0, st_reg, qry_seen_reg, dtr_reg,
    tx_reg.valid, talk_only, native};
  wire logic [31:0] cfg_w = {10'h0, cfg_reg.lang, 2'h0, cfg_reg.par, 1'b0, cfg_reg.baud,
    3'h0, cfg_reg.serial_sel, 3'h0, cfg_reg.addr};
  wire logic [31:0] rd_w = hit_cfg ? cfg_w :
    (wb_adr_i == IRI_STAT_OFF) ? stat_w :
    hit_txd ? {24'h0, tx_reg.data} :
    hit_rdg ? {27'h0, idx_reg} : 32'h0;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_reg <= 1'b0;
      rd_reg <= 32'h0;
    end else begin
      ack_reg <= acc;
      rd_reg <= rd_w;
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rd_reg;
endmodule

// ===== iri_pkg.sv
package iri_pkg;
  // wishbone register byte offsets
  localparam logic [7:0] IRI_CFG_OFF = 8'h00;
  localparam logic [7:0] IRI_CMD_OFF = 8'h04;
  localparam logic [7:0] IRI_STAT_OFF = 8'h08;
  localparam logic [7:0] IRI_RDG_OFF = 8'h0c;
  localparam logic [7:0] IRI_TXD_OFF = 8'h10;
  localparam logic [7:0] IRI_QRY_OFF = 8'h14;
  // configuration field positions
  localparam int IRI_ADDR_LSB = 0;
  localparam int IRI_IFSEL_BIT = 8;
  localparam int IRI_BAUD_LSB = 12;
  localparam int IRI_PAR_LSB = 16;
  localparam int IRI_LANG_LSB = 20;
  // command register bits
  localparam int IRI_CMD_CLR_BIT = 0;
  localparam int IRI_CMD_CAL_BIT = 1;
  localparam int IRI_CMD_LANG_LSB = 4;
  // reset address, talk-only address, characters and lengths
  localparam logic [4:0] IRI_ADDR_RST = 5'h16;
  localparam logic [4:0] IRI_TALK_ONLY = 5'h1f;
  localparam logic [7:0] IRI_CTRL_C = 8'h03;
  localparam logic [7:0] IRI_NL = 8'h0a;
  localparam logic [7:0] IRI_CR = 8'h0d;
  localparam logic [7:0] IRI_COMMA = 8'h2c;
  localparam logic [6:0] IRI_QRY_MAX = 7'h4f;
  localparam logic [4:0] IRI_RDG_LEN = 5'h0f;

  typedef enum logic [2:0] {
    IRI_B300 = 3'h0, IRI_B600 = 3'h1, IRI_B1200 = 3'h2,
    IRI_B2400 = 3'h3, IRI_B4800 = 3'h4, IRI_B9600 = 3'h5
  } iri_baud_t;
  typedef enum logic [1:0] {IRI_PAR_NONE = 2'h0, IRI_PAR_EVEN = 2'h1, IRI_PAR_ODD = 2'h2} iri_par_t;
  typedef enum logic [1:0] {
    IRI_LANG_NATIVE = 2'h0, IRI_LANG_LEGACY_A = 2'h1, IRI_LANG_LEGACY_B = 2'h2
  } iri_lang_t;
  localparam logic [1:0] IRI_CMD_NATIVE = 2'h1; // select_native_language_cmd
  localparam logic [1:0] IRI_CMD_LEG_A = 2'h2; // select_legacy_a_language_cmd
  localparam logic [1:0] IRI_CMD_LEG_B = 2'h3; // select_legacy_b_language_cmd

  // non-volatile settings image
  typedef struct packed {
    iri_lang_t lang;
    iri_par_t par;
    iri_baud_t baud;
    logic serial_sel;
    logic [4:0] addr;
  } iri_cfg_t;
  localparam iri_cfg_t IRI_CFG_RST = '{lang: IRI_LANG_NATIVE, par: IRI_PAR_EVEN,
    baud: IRI_B9600, serial_sel: 1'b0, addr: IRI_ADDR_RST};

  // one reading: sign, digit, 8 fraction digits, exponent sign and two digits
  typedef struct packed {
    logic neg;
    logic [3:0] lead;
    logic [31:0] frac;
    logic exp_neg;
    logic [7:0] exp;
  } iri_rdg_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } iri_byte_t;
endpackage

// ===== iri_sink.sv
module iri_sink import iri_pkg::*; (
  input wire logic clk_i,
  input wire iri_pkg::iri_byte_t tx_i,
  output logic ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  int seed = 32'h4714;
  initial ready_o = 1'b0;
  // listen-always printer, accepts or stalls at random
  always @(posedge clk_i) begin
    if (ready_o && tx_i.valid) got.push_back(tx_i.data);
    ready_o <= ($random(seed) % 3) != 0;
  end
endmodule

// ===== iri_top_props.sv
module iri_top_props (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic nv_rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic dev_clear_i,
  input wire iri_pkg::iri_byte_t rx_i,
  input wire logic tx_ready_i,
  input wire iri_pkg::iri_byte_t tx_o,
  input wire logic talk_only_o,
  input wire logic par_en_o,
  input wire logic ser_en_o,
  input wire logic meas_abort_o,
  input wire logic trig_idle_o,
  input wire logic parse_restart_o,
  input wire logic cal_exec_o,
  input wire logic selftest_o,
  input wire logic dtr_o,
  input wire iri_pkg::iri_cfg_t cfg_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import iri_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i || !nv_rst_n_i);
  // interface selection and talk-only decode
  a_one_iface: assert property (par_en_o == !ser_en_o && ser_en_o == cfg_o.serial_sel)
    else $error("interface enables wrong");
  a_talk_only: assert property (talk_only_o == (cfg_o.addr == IRI_TALK_ONLY))
    else $error("talk only flag wrong");
  // clear actions one cycle later
  a_clear_abort: assert property (dev_clear_i |=> meas_abort_o && trig_idle_o)
    else $error("clear did not abort");
  a_clear_parse: assert property (dev_clear_i |=> parse_restart_o)
    else $error("clear did not restart parse");
  a_ctrl_c: assert property (rx_i.valid && rx_i.data == IRI_CTRL_C && ser_en_o
    |=> meas_abort_o ##0 parse_restart_o) else $error("control-c not a clear");
  a_dtr_true: assert property (meas_abort_o |-> dtr_o [*2])
    else $error("dtr low after clear");
  a_cfg_kept: assert property (dev_clear_i && !(wb_cyc_i && wb_stb_i && wb_we_i)
    |=> $stable(cfg_o)) else $error("clear changed settings");
  a_cal_native: assert property (cal_exec_o |-> cfg_o.lang == IRI_LANG_NATIVE)
    else $error("calibration outside native");
  a_no_selftest: assert property (!selftest_o)
    else $error("self-test ran");
  a_tx_hold: assert property (tx_o.valid && !tx_ready_i && !dev_clear_i && !rx_i.valid
    |=> $stable(tx_o)) else $error("tx char changed while stalled");
endmodule
bind iri_top iri_top_props iri_top_props_inst (.clk_i, .rst_n_i, .nv_rst_n_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .dev_clear_i, .rx_i, .tx_ready_i, .tx_o, .talk_only_o, .par_en_o,
  .ser_en_o, .meas_abort_o, .trig_idle_o, .parse_restart_o, .cal_exec_o, .selftest_o,
  .dtr_o, .cfg_o);

// ===== iri_testbench.sv
module testbench import iri_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_n = 1'b0, nv_n = 1'b0, cyc = 1'b0, we = 1'b0, clr = 1'b0;
  logic loc = 1'b0, rv = 1'b0, rl = 1'b0, ack, rdy, talk, pe, se, cal, dtr, self, trdy;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0, rd, q;
  iri_byte_t rx = '0, tx;
  iri_rdg_t rdg = '0;
  iri_cfg_t cfg, m = IRI_CFG_RST;
  int n_errors = 0, n_tests = 0, seed = 32'h4714, n_cal = 0, bad;
  logic [7:0] eq[$];
  iri_top iri_top_inst (.clk_i, .rst_n_i(rst_n), .nv_rst_n_i(nv_n), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd),
    .wb_dat_o(rd), .wb_ack_o(ack), .dev_clear_i(clr), .rx_i(rx), .local_mode_i(loc),
    .rdg_valid_i(rv), .rdg_i(rdg), .rdg_last_i(rl), .rdg_ready_o(rdy), .tx_o(tx),
    .tx_ready_i(trdy), .talk_only_o(talk), .par_en_o(pe), .ser_en_o(se),
    .meas_abort_o(), .trig_idle_o(), .parse_restart_o(), .cal_exec_o(cal),
    .selftest_o(self), .dtr_o(dtr), .cfg_o(cfg));
  iri_sink iri_sink_inst (.clk_i, .tx_i(tx), .ready_o(trdy));
  // 250 MHz clock and calibration pulse count
  initial forever #2 clk_i = ~clk_i;
  always @(posedge clk_i) if (cal === 1'b1) n_cal++;
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tmo(int n);
    if (n >= 2000) begin
      n_errors++;
      stop_test();
    end
  endtask
  // one classic wishbone cycle, read data lands in q
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
    int n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 2000);
    q = rd;
    cyc <= 1'b0;
    @(posedge clk_i);
    tmo(n);
  endtask
  task automatic set_cfg(logic [31:0] d);
    wb(1'b1, IRI_CFG_OFF, d);
    m.addr = d[4:0];
    m.serial_sel = d[8];
    if (d[14:12] <= 3'h5) m.baud = iri_baud_t'(d[14:12]);
    if (d[17:16] <= 2'h2) m.par = iri_par_t'(d[17:16]);
    if (d[21:20] <= 2'h2) m.lang = iri_lang_t'(d[21:20]);
  endtask
  task automatic chk_cfg();
    wb(1'b0, IRI_CFG_OFF, 0);
    chk("cfg_reg", q, {10'h0, m.lang, 2'h0, m.par, 1'b0, m.baud, 3'h0, m.serial_sel, 3'h0,
      m.addr});
    chk("cfg_o", cfg, m);
    chk("iface", {pe, se}, {!m.serial_sel, m.serial_sel});
    chk("talk", talk, m.addr == IRI_TALK_ONLY);
    wb(1'b0, IRI_STAT_OFF, 0);
    chk("width", q[12:9], m.par == IRI_PAR_NONE ? 8 : 7);
  endtask
  function automatic logic [3:0] dig();
    return 4'(unsigned'($random(seed)) % 10);
  endfunction
  // offer one random reading and queue its expected characters
  task automatic send_rdg(logic last, logic ser);
    int n = 0;
    iri_rdg_t r;
    r.neg = 1'($random(seed));
    r.exp_neg = 1'($random(seed));
    r.lead = dig();
    r.exp = {dig(), dig()};
    for (int i = 0; i < 8; i++) r.frac = {r.frac[27:0], dig()};
    eq.push_back(r.neg ? 8'h2d : 8'h2b);
    eq.push_back({4'h3, r.lead});
    eq.push_back(8'h2e);
    for (int i = 7; i >= 0; i--) eq.push_back({4'h3, r.frac[i*4 +: 4]});
    eq.push_back(8'h45);
    eq.push_back(r.exp_neg ? 8'h2d : 8'h2b);
    eq.push_back({4'h3, r.exp[7:4]});
    eq.push_back({4'h3, r.exp[3:0]});
    eq.push_back(!last ? IRI_COMMA : ser ? IRI_CR : IRI_NL);
    rdg <= r;
    rl <= last;
    rv <= 1'b1;
    do begin @(posedge clk_i); n++; end while (rdy !== 1'b1 && n < 2000);
    rv <= 1'b0;
    @(posedge clk_i);
    tmo(n);
  endtask
  // one query byte once the output register is empty, then read it back
  task automatic qry_byte(logic [7:0] b);
    int n = 0;
    do begin wb(1'b0, IRI_STAT_OFF, 0); n++; end while (q[2] !== 1'b0 && n < 2000);
    tmo(n);
    wb(1'b1, IRI_QRY_OFF, {24'h0, b});
    eq.push_back(b);
    wb(1'b0, IRI_TXD_OFF, 0);
    chk("txd", q[7:0], b);
  endtask
  task automatic drain();
    int n = 0;
    while (iri_sink_inst.got.size() < eq.size() && n < 2000) begin @(posedge clk_i); n++; end
    tmo(n);
    while (eq.size() > 0) chk("tx", iri_sink_inst.got.pop_front(), eq.pop_front());
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk_i);
    rst_n <= 1'b1;
    nv_n <= 1'b1;
    @(posedge clk_i);
    chk_cfg();
    wb(1'b0, 8'h40, 0);
    chk("unmapped", q, 0);
    for (int i = 0; i < 12; i++) begin
      set_cfg($random(seed) & 32'h0037_711f);
      chk_cfg();
    end
    rst_n <= 1'b0;
    @(posedge clk_i);
    rst_n <= 1'b1;
    @(posedge clk_i);
    chk_cfg();
    // language commands, calibrate in each, clear in legacy a
    for (int l = 1; l <= 3; l++) begin
      n_cal = 0;
      wb(1'b1, IRI_CMD_OFF, l << 4);
      m.lang = iri_lang_t'(l - 1);
      wb(1'b1, IRI_CMD_OFF, 32'h2);
      if (l == 2) wb(1'b1, IRI_CMD_OFF, 32'h1);
      chk("cal", n_cal, l == 1);
      chk("selftest", self, 0);
      chk_cfg();
    end
    // bus clear, then control-c, each in mid-reading
    for (int k = 0; k < 2; k++) begin
      set_cfg(k ? 32'h0001_5116 : 32'h0001_5016);
      send_rdg(1'b1, k[0]);
      repeat (4) @(posedge clk_i);
      if (k) rx <= '{1'b1, IRI_CTRL_C};
      else clr <= 1'b1;
      @(posedge clk_i);
      rx <= '0;
      clr <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk("tx_flush", tx.valid, 0);
      chk("dtr", dtr, 1);
      chk_cfg();
      eq.delete();
      iri_sink_inst.got.delete();
      send_rdg(1'b0, k[0]);
      send_rdg(1'b1, k[0]);
      drain();
    end
    // serial talk-only waits for local mode
    set_cfg(32'h0001_511f);
    rv <= 1'b1;
    bad = 0;
    repeat (20) @(posedge clk_i) if (rdy !== 1'b0) bad++;
    chk("held", bad, 0);
    loc <= 1'b1;
    send_rdg(1'b1, 1'b1);
    drain();
    // a short query reply on the parallel bus
    set_cfg(32'h0001_5016);
    qry_byte(8'h4f);
    qry_byte(8'h4b);
    qry_byte(IRI_NL);
    drain();
    stop_test();
  end
endmodule
